// File: shared/rpr_pkg.sv
/*
 package for the remote parameter request framer: frame offsets, codes,
 register map, reset values and the forwarded request descriptor.
 assumes frame offsets count from the start delimiter at offset zero.
*/
package rpr_pkg;
   // serial framing
   localparam logic [7:0]  DELIM          = 8'h7e;
   localparam logic [7:0]  CSUM_GOOD      = 8'hff;
   localparam logic [7:0]  REQ_TYPE       = 8'h17;
   // frame offsets
   localparam logic [15:0] OFS_TYPE       = 16'h0003;
   localparam logic [15:0] OFS_ID         = 16'h0004;
   localparam logic [15:0] OFS_DST64_MSB  = 16'h0005;
   localparam logic [15:0] OFS_DST64_LSB  = 16'h000c;
   localparam logic [15:0] OFS_DST16_MSB  = 16'h000d;
   localparam logic [15:0] OFS_DST16_LSB  = 16'h000e;
   localparam logic [15:0] OFS_OPT        = 16'h000f;
   localparam logic [15:0] OFS_CMD_HI     = 16'h0010;
   localparam logic [15:0] OFS_CMD_LO     = 16'h0011;
   localparam logic [15:0] OFS_PARAM      = 16'h0012;
   localparam logic [15:0] LEN_TO_LAST    = 16'h0002;
   localparam logic [15:0] HDR_BYTES      = 16'h000f;
   // option bits and codes
   localparam logic [7:0]  OPT_NO_ACK     = 8'h01;
   localparam logic [7:0]  OPT_APPLY      = 8'h02;
   localparam logic [7:0]  OPT_EXT_TO     = 8'h40;
   localparam logic [63:0] COORD_ADDR     = 64'h0000000000000000;
   localparam logic [15:0] DST16_UNKNOWN  = 16'hfffe;
   localparam logic [15:0] COMMIT_CMD     = 16'h4143;
   localparam logic [7:0]  NO_RESPONSE_ID = 8'h00;
   // sizes
   localparam int          PARAM_MAX      = 16;
   localparam int          FIFO_DEPTH     = 16;
   // register map
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_STAT      = 4'h4;
   localparam logic [3:0]  ADDR_GOOD      = 4'h8;
   localparam logic [3:0]  ADDR_BAD       = 4'hc;
   localparam logic [31:0] CTRL_RESET     = 32'h00000001;
   localparam int          CTRL_EN_BIT    = 0;

   typedef struct packed {
      logic [7:0]  frame_id;
      logic        respond;
      logic [63:0] dest64;
      logic        to_coord;
      logic [15:0] dest16;
      logic        dest16_unknown;
      logic        no_ack;
      logic        ext_timeout;
      logic        apply;
      logic        commit;
      logic        is_write;
      logic [15:0] command;
      logic [7:0]  param_len;
   } req_t;
endpackage : rpr_pkg

// File: hdl/byte_fifo.sv
/*
 synchronous fifo with valid/ready on both sides.
 assumes one clock; full and empty come from an occupancy count.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         // depth is a power of two, so the pointers wrap by overflow
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
         count_reg <= count_reg - (AW+1)'(1);
      end
   end
endmodule : byte_fifo
`default_nettype wire

// File: hdl/remote_param_request_frame.sv
/*
 parser for the remote parameter request frame arriving as a byte stream
 from the serial interface; emits a forwarding descriptor and pushes the
 parameter bytes through a fifo toward the radio transmit path.
 assumes the byte stream and register port share clk; the descriptor
 consumer and the fifo drain may stall at will.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module remote_param_request_frame
   import rpr_pkg::*;
#(
   parameter int PARAM_BYTES = PARAM_MAX,
   parameter int BUF_DEPTH   = FIFO_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        rst,
   // byte stream from the serial interface
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [7:0]  rx_data,
   // forwarding descriptor toward the radio
   output logic             req_valid,
   input  wire logic        req_ready,
   output req_t             req,
   // parameter bytes toward the radio
   output logic             param_valid,
   input  wire logic        param_ready,
   output logic [7:0]       param_data,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata
);
   localparam int PW = $clog2(PARAM_BYTES);

   typedef enum logic [2:0] {
      S_DELIM, S_LEN_HI, S_LEN_LO, S_DATA, S_CSUM, S_DESC, S_PARAM
   } state_t;

   state_t      state_reg;
   logic [15:0] len_reg;
   logic [15:0] pos_reg;
   logic [7:0]  sum_reg;
   logic [7:0]  type_reg;
   logic [7:0]  id_reg;
   logic [63:0] dest64_reg;
   logic [15:0] dest16_reg;
   logic [7:0]  opt_reg;
   logic [15:0] cmd_reg;
   logic [7:0]  param_mem [PARAM_BYTES];
   logic [7:0]  pidx_reg;
   logic        pending_reg;
   logic [31:0] ctrl_reg;
   logic [15:0] good_reg;
   logic [15:0] bad_reg;
   logic        take;
   logic        csum_ok;
   logic        accept;
   logic [7:0]  plen;
   logic        fifo_in_ready;
   logic        fifo_in_valid;
   logic        desc_done;
   logic        last_param;

   function automatic logic at_ofs(input logic [15:0] pos, input logic [15:0] ofs);
      at_ofs = (pos == ofs);
   endfunction : at_ofs

   // input stalls while a decoded request is being handed on
   assign rx_ready  = (state_reg != S_DESC) && (state_reg != S_PARAM);
   assign take      = rx_valid && rx_ready;
   assign csum_ok   = (8'(sum_reg + rx_data) == CSUM_GOOD);
   assign accept    = csum_ok && (type_reg == REQ_TYPE)
                      && (len_reg >= HDR_BYTES)
                      && ctrl_reg[CTRL_EN_BIT];
   assign plen      = 8'(len_reg - HDR_BYTES);
   assign desc_done = req_valid && req_ready;
   assign last_param = (pidx_reg == plen - 8'h01);

   // frame sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= S_DELIM;
      end else begin
         case (state_reg)
            S_DELIM: begin
               if (take && rx_data == DELIM) begin
                  state_reg <= S_LEN_HI;
               end
            end
            S_LEN_HI: begin
               if (take) begin
                  state_reg <= S_LEN_LO;
               end
            end
            S_LEN_LO: begin
               if (take) begin
                  // oversize frames cannot be buffered and are dropped at once
                  if ({len_reg[7:0], rx_data} > HDR_BYTES + 16'(PARAM_BYTES)) begin
                     state_reg <= S_DELIM;
                  end else if ({len_reg[7:0], rx_data} == 16'h0000) begin
                     state_reg <= S_CSUM;
                  end else begin
                     state_reg <= S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (take && pos_reg == len_reg + LEN_TO_LAST) begin
                  state_reg <= S_CSUM;
               end
            end
            S_CSUM: begin
               if (take) begin
                  state_reg <= accept ? S_DESC : S_DELIM;
               end
            end
            S_DESC: begin
               if (desc_done) begin
                  state_reg <= (plen == 8'h00) ? S_DELIM : S_PARAM;
               end
            end
            S_PARAM: begin
               if (fifo_in_ready && last_param) begin
                  state_reg <= S_DELIM;
               end
            end
            default: begin
               state_reg <= S_DELIM;
            end
         endcase
      end
   end

   // length, position and running checksum
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         len_reg <= '0;
         pos_reg <= '0;
         sum_reg <= '0;
      end else if (take) begin
         case (state_reg)
            S_LEN_HI: begin
               len_reg <= {8'h00, rx_data};
            end
            S_LEN_LO: begin
               len_reg <= {len_reg[7:0], rx_data};
               pos_reg <= OFS_TYPE;
               sum_reg <= '0;
            end
            S_DATA: begin
               pos_reg <= pos_reg + 16'h0001;
               sum_reg <= sum_reg + rx_data;
            end
            default: begin
               pos_reg <= pos_reg;
            end
         endcase
      end
   end

   // field capture; stale fields from short frames are never used
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         type_reg   <= '0;
         id_reg     <= '0;
         dest64_reg <= '0;
         dest16_reg <= '0;
         opt_reg    <= '0;
         cmd_reg    <= '0;
      end else if (take && state_reg == S_LEN_LO) begin
         type_reg <= '0;
      end else if (take && state_reg == S_DATA) begin
         if (at_ofs(pos_reg, OFS_TYPE)) begin
            type_reg <= rx_data;
         end
         if (at_ofs(pos_reg, OFS_ID)) begin
            id_reg <= rx_data;
         end
         if (pos_reg >= OFS_DST64_MSB && pos_reg <= OFS_DST64_LSB) begin
            dest64_reg <= {dest64_reg[55:0], rx_data};
         end
         if (at_ofs(pos_reg, OFS_DST16_MSB) || at_ofs(pos_reg, OFS_DST16_LSB)) begin
            dest16_reg <= {dest16_reg[7:0], rx_data};
         end
         if (at_ofs(pos_reg, OFS_OPT)) begin
            opt_reg <= rx_data;
         end
         if (at_ofs(pos_reg, OFS_CMD_HI) || at_ofs(pos_reg, OFS_CMD_LO)) begin
            cmd_reg <= {cmd_reg[7:0], rx_data};
         end
      end
   end

   // parameter bytes are held until the checksum clears the frame
   always_ff @(posedge clk) begin
      if (take && state_reg == S_DATA && pos_reg >= OFS_PARAM) begin
         param_mem[PW'(pos_reg - OFS_PARAM)] <= rx_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pidx_reg <= '0;
      end else if (state_reg == S_DESC) begin
         pidx_reg <= '0;
      end else if (state_reg == S_PARAM && fifo_in_ready) begin
         pidx_reg <= pidx_reg + 8'h01;
      end
   end

   // request always goes out over the air, nothing is applied locally
   assign req_valid          = (state_reg == S_DESC);
   assign req.frame_id       = id_reg;
   assign req.respond        = (id_reg != NO_RESPONSE_ID);
   assign req.dest64         = dest64_reg;
   assign req.to_coord       = (dest64_reg == COORD_ADDR);
   assign req.dest16         = dest16_reg;
   assign req.dest16_unknown = (dest16_reg == DST16_UNKNOWN);
   assign req.no_ack         = |(opt_reg & OPT_NO_ACK);
   assign req.ext_timeout    = |(opt_reg & OPT_EXT_TO);
   assign req.apply          = |(opt_reg & OPT_APPLY);
   assign req.commit         = (cmd_reg == COMMIT_CMD);
   assign req.is_write       = (plen != 8'h00);
   assign req.command        = cmd_reg;
   assign req.param_len      = plen;

   // pending write tracking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pending_reg <= 1'b0;
      end else if (desc_done) begin
         if (req.apply || req.commit) begin
            pending_reg <= 1'b0;
         end else if (req.is_write) begin
            pending_reg <= 1'b1;
         end
      end
   end

   assign fifo_in_valid = (state_reg == S_PARAM);

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (BUF_DEPTH)
   ) u_param_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (param_mem[PW'(pidx_reg)]),
      .out_valid (param_valid),
      .out_ready (param_ready),
      .out_data  (param_data)
   );

   // register port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         ctrl_reg <= {31'h00000000, reg_wdata[CTRL_EN_BIT]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         good_reg <= '0;
         bad_reg  <= '0;
      end else begin
         if (desc_done) begin
            good_reg <= good_reg + 16'h0001;
         end
         if (take && state_reg == S_CSUM && (!csum_ok || len_reg < HDR_BYTES)) begin
            bad_reg <= bad_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_CTRL: reg_rdata <= ctrl_reg;
            ADDR_STAT: reg_rdata <= {27'h0000000, 3'(state_reg), rx_ready, pending_reg};
            ADDR_GOOD: reg_rdata <= {16'h0000, good_reg};
            ADDR_BAD:  reg_rdata <= {16'h0000, bad_reg};
            default:   reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   type_gate_a: assert property (
      $rose(req_valid) |-> type_reg == REQ_TYPE && $past(state_reg) == S_CSUM)
      else $error("request issued for a foreign frame type");

   id_echo_a: assert property (
      req_valid |-> req.frame_id == id_reg && $stable(id_reg))
      else $error("correlation id not held with the request");

   id_capture_a: assert property (
      take && state_reg == S_DATA && at_ofs(pos_reg, OFS_ID) |=> id_reg == $past(rx_data))
      else $error("correlation id not taken from its offset");

   silent_id_a: assert property (
      req_valid && id_reg == NO_RESPONSE_ID |-> !req.respond)
      else $error("response not suppressed for id zero");

   dest_order_a: assert property (
      take && state_reg == S_DATA && pos_reg == OFS_DST64_LSB
      |=> dest64_reg[7:0] == $past(rx_data) && dest64_reg[63:8] == $past(dest64_reg[55:0]))
      else $error("64-bit destination not shifted msb first");

   coord_addr_a: assert property (
      req_valid |-> req.to_coord == (req.dest64 == COORD_ADDR))
      else $error("coordinator address not recognised");

   no_ack_a: assert property (
      req_valid |-> req.no_ack == opt_reg[0])
      else $error("acknowledge option misread");

   ext_timeout_a: assert property (
      req_valid |-> req.ext_timeout == opt_reg[6])
      else $error("extended timeout option misread");

   read_query_a: assert property (
      req_valid && len_reg == HDR_BYTES |-> !req.is_write ##0 !fifo_in_valid)
      else $error("empty parameter not treated as query");

   pending_hold_a: assert property (
      desc_done && req.is_write && !req.apply && !req.commit |=> pending_reg [*2])
      else $error("written setting not left pending");

   commit_clear_a: assert property (
      desc_done && (req.apply || req.commit) |=> !pending_reg)
      else $error("pending setting not committed");

   bad_csum_a: assert property (
      take && state_reg == S_CSUM && !csum_ok |=> state_reg == S_DELIM ##1 !req_valid)
      else $error("frame with bad checksum decoded");

   short_drop_a: assert property (
      take && state_reg == S_CSUM && len_reg < HDR_BYTES |=> !req_valid)
      else $error("truncated frame not discarded");

   param_count_a: assert property (
      state_reg == S_PARAM && fifo_in_ready && last_param |=> state_reg == S_DELIM)
      else $error("parameter transfer length wrong");
endmodule : remote_param_request_frame
`default_nettype wire

// File: verification/host_model.sv
/*
 host controller model: sends framed requests as a byte stream.
 assumes the parser's rx_ready handshake and a shared clk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   input  wire logic       rx_ready,
   output logic            rx_valid,
   output logic      [7:0] rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end

   // byte held until rx_ready is sampled high
   task automatic put(input logic [7:0] b);
      rx_valid <= 1'b1;
      rx_data  <= b;
      do @(posedge clk); while (rx_ready !== 1'b1);
   endtask : put

   // delimiter, big-endian length, data, checksum
   // dest16 travels in the body as the caller built it
   task automatic send(input logic [7:0] body[$], input logic bad_sum);
      logic [7:0]  sum;
      logic [15:0] len;
      sum = 8'h00;
      len = 16'(body.size());
      @(posedge clk);
      put(8'h7e);
      put(len[15:8]);
      put(len[7:0]);
      foreach (body[i]) begin
         put(body[i]);
         sum = sum + body[i];
      end
      put((8'hff - sum) ^ {7'h00, bad_sum});
      rx_valid <= 1'b0;
      // idle line shows the inverse, so a stale byte cannot pass as data
      rx_data  <= ~rx_data;
   endtask : send
endmodule : host_model
`default_nettype wire

// File: verification/remote_param_request_frame_tb.sv
/*
 testbench for the remote parameter request parser: frames from the host
 model, descriptor and fifo drains, register port reads and writes.
 assumes rpr_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_param_request_frame_tb;
   import rpr_pkg::*;
   typedef logic [7:0] bq_t[$];
   logic        clk, rst, rx_valid, rx_ready, req_valid, req_ready;
   logic        param_valid, param_ready, reg_wr, reg_rd;
   logic [7:0]  rx_data, param_data;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   req_t        req;
   int          err_total, n_checks;
   bq_t         pq, fq;

   remote_param_request_frame #(.PARAM_BYTES(16), .BUF_DEPTH(16)) u_remote_param_request_frame (
      .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .param_valid(param_valid), .param_ready(param_ready), .param_data(param_data),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   host_model u_host_model (
      .clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic summarize;
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk32

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string name);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      chk32(name, e, reg_rdata & m);
   endtask : rreg

   function automatic bq_t frame(input logic [7:0] ty, input logic [7:0] id,
      input logic [63:0] d64, input logic [15:0] d16, input logic [7:0] opt,
      input logic [15:0] cmd, input int np);
      bq_t q;
      q = {ty, id};
      for (int i = 7; i >= 0; i--) q.push_back(d64[8*i +: 8]);
      q.push_back(d16[15:8]);
      q.push_back(d16[7:0]);
      q.push_back(opt);
      q.push_back(cmd[15:8]);
      q.push_back(cmd[7:0]);
      for (int i = 0; i < np; i++) q.push_back(8'(i * 7 + np));
      return q;
   endfunction : frame

   task automatic take_req(input req_t e);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req_valid !== 1'b1 && n < 200);
      chk32("req_valid", 32'h1, {31'h0, req_valid});
      n_checks++;
      if (req !== e) begin
         err_total++;
         $display("[FAIL] req expected %h seen %h", e, req);
      end
      req_ready <= 1'b1;
      @(posedge clk);
      req_ready <= 1'b0;
   endtask : take_req

   task automatic run_req(input logic [7:0] id, input logic [63:0] d64,
      input logic [15:0] d16, input logic [7:0] opt, input logic [15:0] cmd, input int np);
      bq_t  q;
      req_t e;
      q = frame(8'h17, id, d64, d16, opt, cmd, np);
      for (int i = 15; i < q.size(); i++) pq.push_back(q[i]);
      e.frame_id       = id;
      e.respond        = (id != 8'h00);
      e.dest64         = d64;
      e.to_coord       = (d64 == 64'h0000000000000000);
      e.dest16         = d16;
      e.dest16_unknown = (d16 == 16'hfffe);
      e.no_ack         = opt[0];
      e.ext_timeout    = opt[6];
      e.apply          = opt[1];
      e.commit         = (cmd == 16'h4143);
      e.is_write       = (np != 0);
      e.command        = cmd;
      e.param_len      = 8'(np);
      u_host_model.send(q, 1'b0);
      take_req(e);
   endtask : run_req

   task automatic no_req;
      logic seen;
      seen = 1'b0;
      repeat (60) begin
         @(posedge clk);
         if (req_valid === 1'b1) seen = 1'b1;
      end
      chk32("no_descriptor", 32'h0, {31'h0, seen});
   endtask : no_req

   task automatic drain(input int n);
      int k;
      param_ready <= 1'b1;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (param_valid !== 1'b1 && k < 100);
         chk32("param_data", {24'h0, pq.pop_front()}, {24'h0, param_data});
      end
      param_ready <= 1'b0;
   endtask : drain

   // bounded by a generous multiple of the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      summarize();
   end

   initial begin
      err_total   = 0;
      n_checks    = 0;
      rst         = 1'b1;
      req_ready   = 1'b0;
      param_ready = 1'b0;
      reg_addr    = 4'h0;
      reg_wdata   = 32'h00000000;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rreg(4'h0, 32'hffffffff, 32'h1, "ctrl");
      rreg(4'h4, 32'h3, 32'h2, "stat_idle");
      rreg(4'h8, 32'hffffffff, 32'h0, "good");
      rreg(4'hc, 32'hffffffff, 32'h0, "bad");
      wreg(4'h2, 32'hffffffff);
      rreg(4'h2, 32'hffffffff, 32'h0, "unmapped");
      run_req(8'h01, 64'h0013a20040401122, 16'hfffe, 8'h41, 16'h4248, 0);
      rreg(4'h4, 32'h1, 32'h0, "pending");
      run_req(8'h00, 64'h0, 16'h1234, 8'h02, 16'h4248, 3);
      drain(3);
      rreg(4'h4, 32'h1, 32'h0, "pending");
      run_req(8'h7f, 64'h8000000000000001, 16'h0001, 8'h00, 16'h4e49, 1);
      drain(1);
      rreg(4'h4, 32'h1, 32'h1, "pending");
      run_req(8'h05, 64'h1, 16'hfffe, 8'h00, 16'h4e49, 0);
      rreg(4'h4, 32'h1, 32'h1, "pending");
      run_req(8'h06, 64'h1, 16'hfffe, 8'h00, 16'h4143, 0);
      rreg(4'h4, 32'h1, 32'h0, "pending");
      fq = frame(8'h17, 8'h09, 64'h2, 16'h0002, 8'h00, 16'h4248, 2);
      u_host_model.send(fq, 1'b1);
      no_req();
      fq = frame(8'h17, 8'h09, 64'h2, 16'h0002, 8'h00, 16'h4248, 0);
      void'(fq.pop_back());
      u_host_model.send(fq, 1'b0);
      no_req();
      fq = frame(8'h11, 8'h09, 64'h2, 16'h0002, 8'h00, 16'h4248, 0);
      u_host_model.send(fq, 1'b0);
      no_req();
      // oversize frame is dropped at its length and not counted as bad
      fq = frame(8'h17, 8'h09, 64'h2, 16'h0002, 8'h00, 16'h4248, 17);
      u_host_model.send(fq, 1'b0);
      no_req();
      fq.delete();
      u_host_model.send(fq, 1'b0);
      no_req();
      rreg(4'hc, 32'hffffffff, 32'h3, "bad");
      wreg(4'h0, 32'h0);
      fq = frame(8'h17, 8'h09, 64'h2, 16'h0002, 8'h00, 16'h4248, 0);
      u_host_model.send(fq, 1'b0);
      no_req();
      wreg(4'h0, 32'h1);
      // fifo filled while the drain stalls, then emptied in order
      run_req(8'h0a, 64'h3, 16'h0003, 8'h00, 16'h5a5a, 16);
      run_req(8'h0b, 64'h4, 16'h0004, 8'h40, 16'h5a5a, 3);
      repeat (20) @(posedge clk);
      chk32("rx_ready_full", 32'h0, {31'h0, rx_ready});
      drain(19);
      repeat (3) @(posedge clk);
      chk32("param_valid", 32'h0, {31'h0, param_valid});
      rreg(4'h8, 32'hffffffff, 32'h7, "good");
      summarize();
   end
endmodule : remote_param_request_frame_tb
`default_nettype wire
